// *** verilog/sensor_line_command_and_framer.sv ***
// serial line command interpreter, data message builder and framer
// Notes on behaviour
// - bare relay command reports three relay states
// - relay ON forces all relays on
// - numbered relay ON forced until ESC
// - operator commands ignored until line opened
// - open needs configured identifier when one exists
// - asterisk or Ctrl+C opens any identifier
// - open with type tag and id number
// - successful open sends opened acknowledgement
// - sixty seconds silence closes command mode
// - close command releases line, sends acknowledgement
// - frames only on polled or automatic data
// - frame head SOH, tag, space, id, STX
// - frame tail ETX, CR, LF
// - identifier two wide, space one when unset
// - diagnostic status digit zero to four
// - visibility alarm digit zero to three
// - message 0 status and two visibilities
// - message 1 visibility, precip code, intensity
// - message 2 full weather line, capped visibility
// - reset selects message 2 as default
// - message 3 equals the status report
// - status report grows per active alarm
// - line defaults 9600 7 even 1
// - service character blocks multipoint ten seconds
`timescale 1ns/1ps
`default_nettype none

module sensor_line_command_and_framer
  import sensor_line_pkg::*;
#(
  parameter int INACT_CYCLES = int'(INACT_CYCLES_DEF),
  parameter int SVC_CYCLES = int'(SVC_CYCLES_DEF),
  parameter int LINE_MAX = LINE_MAX_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic svcValid,
  input wire logic [7:0] svcData,
  input wire logic mpValid,
  input wire logic [7:0] mpData,
  input wire logic idSet,
  input wire logic [15:0] unitId,
  input wire logic [3:0] idNumber,
  input wire logic autoMsgValid,
  input wire logic [1:0] autoMsgNum,
  input wire logic autoSend,
  input wire meas_s meas,
  input wire logic [NUM_ALARMS-1:0] alarmFlags,
  input wire logic [NUM_RELAYS-1:0] relayAlarm,
  input wire logic txReady,
  output logic txValid,
  output logic [7:0] txData,
  output logic [NUM_RELAYS-1:0] relayOut,
  output logic cmdMode,
  output logic mpBlocked,
  output serial_cfg_s serialCfg
);

  if (INACT_CYCLES < 2 || longint'(INACT_CYCLES) >= (longint'(1) << CNT_W)) begin : g_chk_inact
    $error("inactivity count out of range");
  end
  if (SVC_CYCLES < 2 || longint'(SVC_CYCLES) >= (longint'(1) << CNT_W)) begin : g_chk_svc
    $error("service hold count out of range");
  end
  if (LINE_MAX < 10 || LINE_MAX > 16) begin : g_chk_line
    $error("line buffer must hold 10 to 16 characters");
  end

  function automatic logic [7:0] digitChar(input logic [3:0] d);
    return CH_ZERO | {4'h0, d};
  endfunction

  // leading zeros become spaces so each field ends in the same column
  function automatic logic [39:0] fmtNum(input logic [19:0] b);
    logic lead;
    logic [39:0] r;
    lead = 1'b1;
    r = '0;
    for (int i = 4; i >= 0; i--) begin
      if (b[4*i +: 4] != 4'h0 || i == 0) begin
        lead = 1'b0;
      end
      r[8*i +: 8] = lead ? CH_SPACE : digitChar(b[4*i +: 4]);
    end
    return r;
  endfunction

  function automatic logic [39:0] fmtDec(input logic [15:0] b);
    logic [7:0] tens;
    tens = (b[15:12] == 4'h0) ? CH_SPACE : digitChar(b[15:12]);
    return {tens, digitChar(b[11:8]), CH_DOT, digitChar(b[7:4]), digitChar(b[3:0])};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  line_mode_e mode;
  line_mode_e next_mode;
  logic [7:0] lineBuf [LINE_MAX];
  logic [4:0] lineLen;
  logic [CNT_W-1:0] inactCnt;
  logic [CNT_W-1:0] svcCnt;
  logic [NUM_RELAYS-1:0] relayForce;
  logic [1:0] defaultMsg;
  logic [TXW-1:0] txLine;
  logic [6:0] txLeft;
  logic [7:0] slot1;
  logic slot1Valid;

  ////////////////////////////////////////////////////////////////////////////
  // input arbitration and line assembly

  wire svcTake = svcValid;
  wire mpTake = mpValid && !svcValid && !mpBlocked;
  wire rxTake = svcTake || mpTake;
  wire [7:0] rxChar = svcTake ? svcData : mpData;
  wire lineDone = rxTake && rxChar == CH_CR;
  wire escSeen = rxTake && rxChar == CH_ESC;
  wire lineFull = lineLen >= 5'(LINE_MAX);

  wire [15:0] effId = idSet ? unitId : NO_ID_FIELD;
  wire [31:0] word4 = {lineBuf[0], lineBuf[1], lineBuf[2], lineBuf[3]};
  wire [39:0] word5 = {word4, lineBuf[4]};
  wire sp4 = lineBuf[4] == CH_SPACE;
  wire sp5 = lineBuf[5] == CH_SPACE;

  ////////////////////////////////////////////////////////////////////////////
  // command decode on the completed line

  wire isOpen = word4 == WORD_OPEN;
  wire openBare = isOpen && lineLen == 5'd4 && !idSet;
  wire openWild = isOpen && lineLen == 5'd6 && sp4 &&
                  (lineBuf[5] == CH_STAR || lineBuf[5] == CH_CTRLC);
  wire openId1 = isOpen && lineLen == 5'd6 && sp4 && idSet &&
                 {CH_SPACE, lineBuf[5]} == unitId;
  wire openId2 = isOpen && lineLen == 5'd7 && sp4 && idSet &&
                 {lineBuf[5], lineBuf[6]} == unitId;
  wire openNum = isOpen && lineLen == 5'd9 && sp4 &&
                 {lineBuf[5], lineBuf[6]} == SENSOR_TYPE_TAG &&
                 lineBuf[7] == CH_SPACE && lineBuf[8] == digitChar(idNumber);
  wire openOk = openBare || openWild || openId1 || openId2 || openNum;

  wire closeCmd = word5 == WORD_CLOSE && lineLen == 5'd5;
  wire rptCmd = word4[31:8] == WORD_RPT && lineLen == 5'd3;
  wire isRelay = word5 == WORD_RELAY;
  wire relayQuery = isRelay && lineLen == 5'd5;
  wire relayAllOn = isRelay && lineLen == 5'd8 && sp5 &&
                    {lineBuf[6], lineBuf[7]} == WORD_ON;
  wire [7:0] relayDigit = lineBuf[6] - CH_ONE;
  wire relayOneOn = isRelay && lineLen == 5'd10 && sp5 &&
                    lineBuf[6] >= CH_ONE && relayDigit < 8'(NUM_RELAYS) &&
                    lineBuf[7] == CH_SPACE && {lineBuf[8], lineBuf[9]} == WORD_ON;

  // poll line: ENQ tag [space id [space msg]]
  wire pollHead = lineBuf[0] == CH_ENQ && {lineBuf[1], lineBuf[2]} == SENSOR_TYPE_TAG;
  wire pollOneId = lineLen == 5'd5 || sp5;
  wire [15:0] pollId = pollOneId ? {CH_SPACE, lineBuf[4]} : {lineBuf[4], lineBuf[5]};
  wire [4:0] msgPos = pollOneId ? 5'd6 : 5'd7;
  wire [7:0] pollMsgCh = lineBuf[msgPos[3:0]];
  wire pollHasMsg = lineLen == msgPos + 5'd1 && lineBuf[msgPos[3:0] - 4'd1] == CH_SPACE;
  wire pollMsgOk = pollMsgCh >= CH_ZERO && pollMsgCh <= (CH_ZERO | 8'h03);
  wire pollBare = pollHead && lineLen == 5'd3 && !idSet;
  wire pollWithId = pollHead && lineLen >= 5'd5 && lineBuf[3] == CH_SPACE &&
                    pollId == effId &&
                    (lineLen == (pollOneId ? 5'd5 : 5'd6) || (pollHasMsg && pollMsgOk));
  wire pollOk = pollBare || pollWithId;
  wire [1:0] pollMsg = (pollWithId && pollHasMsg) ? pollMsgCh[1:0] : defaultMsg;

  ////////////////////////////////////////////////////////////////////////////
  // reply selection

  logic startReq;
  tx_kind_e startKind;
  logic [1:0] selMsg;

  always_comb begin
    startReq = 1'b0;
    startKind = TX_DATA;
    selMsg = defaultMsg;
    if (lineDone && mode == MODE_AUTO) begin
      if (openOk) begin
        startReq = 1'b1;
        startKind = TX_OPENED;
      end else if (pollOk) begin
        startReq = 1'b1;
        selMsg = pollMsg;
      end
    end else if (lineDone) begin
      if (closeCmd) begin
        startReq = 1'b1;
        startKind = TX_CLOSED;
      end else if (relayQuery) begin
        startReq = 1'b1;
        startKind = TX_RELAYS;
      end else if (rptCmd) begin
        startReq = 1'b1;
        startKind = TX_STATUS;
      end
    end else if (autoSend && mode == MODE_AUTO) begin
      startReq = 1'b1;
    end
  end

  // a request that meets a message still in flight is dropped
  wire startGo = startReq && txLeft == 7'd0;

  ////////////////////////////////////////////////////////////////////////////
  // message bodies

  wire [19:0] vis1Cap = (meas.vis1 > VIS_CAP) ? VIS_CAP : meas.vis1;
  wire [19:0] vis10Cap = (meas.vis10 > VIS_CAP) ? VIS_CAP : meas.vis10;
  wire [39:0] vis1F = fmtNum(vis1Cap);
  wire [39:0] vis10F = fmtNum(vis10Cap);
  wire [39:0] precipF = fmtNum({12'h000, meas.precip});
  wire [39:0] wInstF = fmtNum({12'h000, meas.wInst});
  wire [39:0] w15F = fmtNum({12'h000, meas.w15});
  wire [39:0] w60F = fmtNum({12'h000, meas.w60});
  wire [39:0] intF = fmtDec(meas.waterInt);
  wire [39:0] sumF = fmtDec(meas.waterSum);
  wire [39:0] snowF = fmtNum({8'h00, meas.snowSum});
  wire [15:0] statPair = {digitChar(meas.diag), digitChar(meas.visAlarm)};

  wire [8*14-1:0] body0 = {statPair, CH_SPACE, vis1F, CH_SPACE, vis10F};
  wire [8*17-1:0] body1 = {statPair, CH_SPACE, vis1F, CH_SPACE, precipF[15:0],
                           CH_SPACE, intF};
  wire [8*42-1:0] body2 = {statPair, CH_SPACE, vis1F, CH_SPACE, vis10F, CH_SPACE,
                           meas.nws, CH_SPACE, wInstF[15:0], CH_SPACE, w15F[15:0],
                           CH_SPACE, w60F[15:0], CH_SPACE, intF, CH_SPACE, sumF,
                           CH_SPACE, snowF[23:0]};
  wire [55:0] frameHead = {CH_SOH, SENSOR_TYPE_TAG, CH_SPACE, effId, CH_STX};

  logic [TXW-1:0] statusVec;
  logic [6:0] statusLen;
  logic [TXW-1:0] relayVec;
  logic [6:0] relayLen;
  logic [TXW-1:0] bodyVec;
  logic [6:0] bodyLen;
  logic [TXW-1:0] newLine;
  logic [6:0] newLen;

  always_comb begin
    statusVec = TXW'(TXT_STATUS);
    statusLen = 7'd6;
    for (int i = 0; i < NUM_ALARMS; i++) begin
      if (alarmFlags[i]) begin
        statusVec = (statusVec << 24) | TXW'({CH_SPACE, CH_ALARM, digitChar(4'(i))});
        statusLen = statusLen + 7'd3;
      end
    end
    relayVec = TXW'(TXT_RELAYS);
    relayLen = 7'd6;
    for (int r = 0; r < NUM_RELAYS; r++) begin
      if (relayOut[r]) begin
        relayVec = (relayVec << 24) | TXW'({CH_SPACE, WORD_ON});
        relayLen = relayLen + 7'd3;
      end else begin
        relayVec = (relayVec << 32) | TXW'({CH_SPACE, 24'h4F4646});
        relayLen = relayLen + 7'd4;
      end
    end
  end

  always_comb begin
    case (selMsg)
      2'h0: begin
        bodyVec = TXW'(body0);
        bodyLen = 7'd14;
      end
      2'h1: begin
        bodyVec = TXW'(body1);
        bodyLen = 7'd17;
      end
      2'h2: begin
        bodyVec = TXW'(body2);
        bodyLen = 7'd42;
      end
      default: begin
        bodyVec = statusVec;
        bodyLen = statusLen;
      end
    endcase
  end

  // lines are assembled right-aligned, then moved to the top for streaming
  always_comb begin
    case (startKind)
      TX_OPENED: begin
        newLine = TXW'({TXT_OPENED, CH_CR, CH_LF});
        newLen = 7'd35;
      end
      TX_CLOSED: begin
        newLine = TXW'({TXT_CLOSED, CH_CR, CH_LF});
        newLen = 7'd13;
      end
      TX_RELAYS: begin
        newLine = (relayVec << 16) | TXW'({CH_CR, CH_LF});
        newLen = relayLen + 7'd2;
      end
      TX_STATUS: begin
        newLine = (statusVec << 16) | TXW'({CH_CR, CH_LF});
        newLen = statusLen + 7'd2;
      end
      default: begin
        newLine = (TXW'(frameHead) << {bodyLen + 7'd3, 3'b000}) | (bodyVec << 24) |
                  TXW'({CH_ETX, CH_CR, CH_LF});
        newLen = bodyLen + 7'd10;
      end
    endcase
  end

  wire [9:0] alignShift = {7'(TX_MAX) - newLen, 3'b000};
  wire [TXW-1:0] txLoad = newLine << alignShift;

  ////////////////////////////////////////////////////////////////////////////
  // mode and timers

  wire inactExpire = mode == MODE_CMD && !rxTake && inactCnt == CNT_W'(1);

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_AUTO: begin
        if (lineDone && openOk) begin
          next_mode = MODE_CMD;
        end
      end
      MODE_CMD: begin
        if ((lineDone && closeCmd) || inactExpire) begin
          next_mode = MODE_AUTO;
        end
      end
      default: next_mode = MODE_AUTO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= MODE_AUTO;
      cmdMode <= 1'b0;
      inactCnt <= '0;
    end else if (ce) begin
      mode <= next_mode;
      cmdMode <= next_mode == MODE_CMD;
      if (next_mode == MODE_CMD && (rxTake || mode == MODE_AUTO)) begin
        inactCnt <= CNT_W'(INACT_CYCLES);
      end else if (inactCnt != '0) begin
        inactCnt <= inactCnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      svcCnt <= '0;
      mpBlocked <= 1'b0;
    end else if (ce) begin
      if (svcTake) begin
        svcCnt <= CNT_W'(SVC_CYCLES);
        mpBlocked <= 1'b1;
      end else if (lineDone && closeCmd && mode == MODE_CMD) begin
        svcCnt <= '0;
        mpBlocked <= 1'b0;
      end else if (svcCnt != '0) begin
        svcCnt <= svcCnt - CNT_W'(1);
        mpBlocked <= svcCnt != CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line buffer, relays and configuration

  always_ff @(posedge clk) begin
    if (rst) begin
      lineLen <= 5'd0;
    end else if (ce && rxTake) begin
      if (rxChar == CH_CR || rxChar == CH_ESC) begin
        lineLen <= 5'd0;
      end else if (rxChar == CH_ENQ) begin
        lineBuf[0] <= CH_ENQ;
        lineLen <= 5'd1;
      end else if (rxChar != CH_LF && !lineFull) begin
        lineBuf[lineLen[3:0]] <= rxChar;
        lineLen <= lineLen + 5'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      relayForce <= '0;
      relayOut <= '0;
    end else if (ce) begin
      if (escSeen) begin
        relayForce <= '0;
      end else if (lineDone && mode == MODE_CMD && relayAllOn) begin
        relayForce <= '1;
      end else if (lineDone && mode == MODE_CMD && relayOneOn) begin
        relayForce[relayDigit[1:0]] <= 1'b1;
      end
      relayOut <= relayForce | relayAlarm;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      defaultMsg <= RESET_DEFAULT_MSG;
      serialCfg <= '{DEF_BAUD, DEF_DATA_BITS, DEF_PARITY_EVEN, DEF_STOP_BITS};
    end else if (ce && autoMsgValid) begin
      defaultMsg <= autoMsgNum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer and two-entry output buffer

  wire bufInReady = !slot1Valid;
  wire push = txLeft != 7'd0 && bufInReady;
  wire pop = txValid && txReady;
  wire [7:0] genByte = txLine[TXW-1 -: 8];

  always_ff @(posedge clk) begin
    if (rst) begin
      txLeft <= 7'd0;
      txLine <= '0;
    end else if (ce) begin
      if (startGo) begin
        txLine <= txLoad;
        txLeft <= newLen;
      end else if (push) begin
        txLine <= txLine << 8;
        txLeft <= txLeft - 7'd1;
      end
    end
  end

  // the second slot absorbs the byte already launched when the receiver stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      txValid <= 1'b0;
      txData <= 8'h00;
      slot1Valid <= 1'b0;
      slot1 <= 8'h00;
    end else if (ce) begin
      if (pop && slot1Valid) begin
        txData <= slot1;
        slot1Valid <= push;
        slot1 <= genByte;
      end else if (pop) begin
        txValid <= push;
        txData <= genByte;
      end else if (push && !txValid) begin
        txValid <= 1'b1;
        txData <= genByte;
      end else if (push) begin
        slot1Valid <= 1'b1;
        slot1 <= genByte;
      end
    end
  end

endmodule

`default_nettype wire

// *** verilog/sensor_line_pkg.sv ***
// shared constants, types and text for the sensor line command and framing block
package sensor_line_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int INACT_TIME_S = 60;
  localparam int SVC_HOLD_S = 10;
  localparam longint INACT_CYCLES_DEF = longint'(INACT_TIME_S) * longint'(CLK_HZ);
  localparam longint SVC_CYCLES_DEF = longint'(SVC_HOLD_S) * longint'(CLK_HZ);
  localparam int CNT_W = 30;

  localparam int LINE_MAX_DEF = 16;
  localparam int TX_MAX = 64;
  localparam int TXW = 8 * TX_MAX;
  localparam int NUM_RELAYS = 3;
  localparam int NUM_ALARMS = 8;

  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_CTRLC = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_ALARM = 8'h41;

  localparam logic [15:0] SENSOR_TYPE_TAG = 16'h5057;
  localparam logic [15:0] NO_ID_FIELD = 16'h2031;
  localparam logic [1:0] RESET_DEFAULT_MSG = 2'h2;
  localparam logic [19:0] VIS_CAP = 20'h20000;

  localparam logic [16:0] DEF_BAUD = 17'h02580;
  localparam logic [3:0] DEF_DATA_BITS = 4'h7;
  localparam logic DEF_PARITY_EVEN = 1'b1;
  localparam logic [1:0] DEF_STOP_BITS = 2'h1;

  localparam logic [8*33-1:0] TXT_OPENED = "LINE OPENED FOR OPERATOR COMMANDS";
  localparam logic [8*11-1:0] TXT_CLOSED = "LINE CLOSED";
  localparam logic [8*6-1:0] TXT_RELAYS = "RELAYS";
  localparam logic [8*6-1:0] TXT_STATUS = "STATUS";
  localparam logic [8*4-1:0] WORD_OPEN = "OPEN";
  localparam logic [8*5-1:0] WORD_CLOSE = "CLOSE";
  localparam logic [8*5-1:0] WORD_RELAY = "RELAY";
  localparam logic [8*3-1:0] WORD_RPT = 24'h535441;
  localparam logic [8*2-1:0] WORD_ON = "ON";

  typedef enum logic {MODE_AUTO, MODE_CMD} line_mode_e;
  typedef enum logic [2:0] {TX_OPENED, TX_CLOSED, TX_RELAYS, TX_STATUS, TX_DATA} tx_kind_e;

  // measurement values in packed BCD, one nibble per decimal digit, except nws which holds two ASCII characters
  typedef struct packed {
    logic [3:0] diag;
    logic [3:0] visAlarm;
    logic [19:0] vis1;
    logic [19:0] vis10;
    logic [15:0] nws;
    logic [7:0] precip;
    logic [7:0] wInst;
    logic [7:0] w15;
    logic [7:0] w60;
    logic [15:0] waterInt;
    logic [15:0] waterSum;
    logic [11:0] snowSum;
  } meas_s;

  typedef struct packed {
    logic [16:0] baud;
    logic [3:0] dataBits;
    logic parityEven;
    logic [1:0] stopBits;
  } serial_cfg_s;

endpackage

// *** bench/sensor_line_command_and_framer_properties.sv ***
// port checks for the sensor line block
`timescale 1ns/1ps
`default_nettype none
module sensor_line_command_and_framer_properties
  import sensor_line_pkg::*;
#(
  parameter int INACT_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic svcValid,
  input wire logic mpValid,
  input wire logic autoSend,
  input wire logic [NUM_RELAYS-1:0] relayAlarm,
  input wire logic txReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic [NUM_RELAYS-1:0] relayOut,
  input wire logic cmdMode,
  input wire logic mpBlocked,
  input wire serial_cfg_s serialCfg
);
  logic [31:0] idleCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // silent cycles in command mode; any accepted character restarts it
  always_ff @(posedge clk) begin
    if (rst || !cmdMode || svcValid || (mpValid && !mpBlocked))
      idleCnt <= 32'h0;
    else
      idleCnt <= idleCnt + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_cfg;
    serialCfg == serial_cfg_s'{17'h02580, 4'h7, 1'b1, 2'h1};
  endproperty
  a_cfg: assert property (p_cfg) else $error("line settings wrong");
  property p_rst;
    $fell(rst) |-> !txValid && !cmdMode && !mpBlocked && relayOut == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_hold;
    txValid && !txReady |=> txValid && $stable(txData);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped under stall");
  property p_mpblk;
    svcValid |=> mpBlocked;
  endproperty
  a_mpblk: assert property (p_mpblk) else $error("multipoint not blocked");
  property p_relay;
    !$past(rst) |-> (relayOut & $past(relayAlarm)) == $past(relayAlarm);
  endproperty
  a_relay: assert property (p_relay) else $error("relay drive lost");
  property p_open;
    $rose(cmdMode) |=> txValid && txData == 8'h4C;
  endproperty
  a_open: assert property (p_open) else $error("no open reply");
  property p_frame;
    autoSend && !cmdMode && !txValid |-> ##2 txValid && txData == CH_SOH;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start wrong");
  property p_inact;
    idleCnt <= 32'(INACT_CYCLES + 2);
  endproperty
  a_inact: assert property (p_inact) else $error("command mode outlived timer");
endmodule

bind sensor_line_command_and_framer sensor_line_command_and_framer_properties #(
  .INACT_CYCLES(INACT_CYCLES)
) u_props (
  .clk(clk), .rst(rst), .svcValid(svcValid), .mpValid(mpValid), .autoSend(autoSend),
  .relayAlarm(relayAlarm), .txReady(txReady), .txValid(txValid), .txData(txData),
  .relayOut(relayOut), .cmdMode(cmdMode), .mpBlocked(mpBlocked), .serialCfg(serialCfg)
);
`default_nettype wire

// *** bench/host_line_model.sv ***
// host side of the line: takes bytes with stalls and reports each one taken
`timescale 1ns/1ps
`default_nettype none
module host_line_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic got,
  output logic [7:0] gotData
);
  // the host may hold off any byte; the block has to keep it standing
  assign txReady = !stall;
  always_ff @(posedge clk) begin
    got <= txValid && txReady;
    gotData <= txData;
  end
endmodule
`default_nettype wire

// *** bench/sensor_line_command_and_framer_tb.sv ***
// self-checking bench for the sensor line block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module sensor_line_command_and_framer_tb;
  import sensor_line_pkg::*;
  localparam int INACT = 200;
  localparam int SVC = 100;
  logic clk, rst, svcValid, mpValid, idSet, autoMsgValid, autoSend, stall, forceStall;
  logic txReady, txValid, cmdMode, mpBlocked, got;
  logic [7:0] svcData, mpData, txData, gotData, alarmFlags;
  logic [15:0] unitId;
  logic [3:0] idNumber;
  logic [1:0] autoMsgNum;
  logic [NUM_RELAYS-1:0] relayAlarm, relayOut;
  meas_s meas;
  logic [31:0] rnd = 32'h23E4;
  logic [8:0] q[$];
  logic [8:0] e;
  string opens[3];
  int fail_count = 0;
  int compares = 0;
  sensor_line_command_and_framer #(.INACT_CYCLES(INACT), .SVC_CYCLES(SVC), .LINE_MAX(16)) DUT (
    .clk(clk), .rst(rst), .ce(1'b1), .svcValid(svcValid), .svcData(svcData),
    .mpValid(mpValid), .mpData(mpData), .idSet(idSet), .unitId(unitId), .idNumber(idNumber),
    .autoMsgValid(autoMsgValid), .autoMsgNum(autoMsgNum), .autoSend(autoSend), .meas(meas),
    .alarmFlags(alarmFlags), .relayAlarm(relayAlarm), .txReady(txReady), .txValid(txValid),
    .txData(txData), .relayOut(relayOut), .cmdMode(cmdMode), .mpBlocked(mpBlocked),
    .serialCfg()
  );
  host_line_model u_host (
    .clk(clk), .stall(stall), .txValid(txValid), .txData(txData), .txReady(txReady),
    .got(got), .gotData(gotData)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(negedge clk) begin
    rnd <= lfsr(rnd);
    stall <= forceStall | (rnd[1:0] == 2'h0);
  end
  // oldest note against each byte the host takes; bit 8 marks a free byte
  always @(negedge clk) begin
    if (got === 1'b1) begin
      if (q.size() == 0) begin
        fail_count++;
        $display("CHECK FAILED txData expected none seen %h", gotData);
      end else begin
        e = q.pop_front();
        if (!e[8]) `CHK("txData", e[7:0], gotData)
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic waitIdle;
    int n;
    repeat (4) @(negedge clk);
    for (n = 0; n < 3000; n++) begin
      if (q.size() == 0 && txValid === 1'b0) break;
      @(negedge clk);
    end
    if (n == 3000) begin
      fail_count++;
      $display("CHECK FAILED idle expected 1 seen 0");
      tally_and_finish;
    end
  endtask
  task automatic expStr(input string s);
    foreach (s[i]) q.push_back({1'b0, s[i]});
  endtask
  task automatic expLine(input string s);
    expStr({s, "\015\012"});
  endtask
  task automatic expHead(input logic [15:0] id);
    logic [7:0] h[7];
    h = '{CH_SOH, SENSOR_TYPE_TAG[15:8], SENSOR_TYPE_TAG[7:0], CH_SPACE, id[15:8], id[7:0],
      CH_STX};
    foreach (h[i]) q.push_back({1'b0, h[i]});
  endtask
  task automatic expTail;
    q.push_back({1'b0, CH_ETX});
    expLine("");
  endtask
  function automatic string vis5(input logic [19:0] v);
    string s = "";
    logic seen = 1'b0;
    if (v > VIS_CAP) v = VIS_CAP;
    for (int i = 4; i >= 0; i--) begin
      if (v[4*i+:4] != 4'h0 || i == 0) seen = 1'b1;
      if (seen) s = {s, string'(CH_ZERO | 8'(v[4*i+:4]))};
      else s = {s, " "};
    end
    return s;
  endfunction
  task automatic expMsg0;
    expHead(unitId);
    q.push_back({1'b0, CH_ZERO | 8'(meas.diag)});
    q.push_back({1'b0, CH_ZERO | 8'(meas.visAlarm)});
    expStr({" ", vis5(meas.vis1), " ", vis5(meas.vis10)});
    expTail;
  endtask
  task automatic sendLine(input string s, input bit svc, input bit cr);
    string t;
    t = cr ? {s, "\015"} : s;
    foreach (t[i]) begin
      @(negedge clk);
      svcValid = svc;
      mpValid = !svc;
      svcData = t[i];
      mpData = t[i];
    end
    @(negedge clk);
    svcValid = 1'b0;
    mpValid = 1'b0;
    waitIdle;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, forceStall} = 2'b10;
    {svcValid, mpValid, idSet, autoMsgValid, autoSend} = 5'h00;
    {svcData, mpData, alarmFlags, autoMsgNum, relayAlarm} = 29'h0;
    unitId = 16'h4142;
    idNumber = 4'h5;
    meas = '0;
    meas.diag = 4'h1;
    meas.visAlarm = 4'h3;
    meas.vis1 = 20'h25000;
    meas.vis10 = 20'h01230;
    meas.nws = "R-";
    repeat (6) @(negedge clk);
    rst = 1'b0;
    expHead(NO_ID_FIELD);
    expStr("13 20000  1230 R-  0  0  0  0.00  0.00   0");
    expTail;
    autoSend = 1'b1;
    @(negedge clk) autoSend = 1'b0;
    waitIdle;
    $display("test default message done");
    idSet = 1'b1;
    autoMsgValid = 1'b1;
    @(negedge clk) autoMsgValid = 1'b0;
    expMsg0;
    forceStall = 1'b1;
    autoSend = 1'b1;
    @(negedge clk) autoSend = 1'b0;
    repeat (30) @(negedge clk);
    forceStall = 1'b0;
    waitIdle;
    $display("test message 0 under stall done");
    sendLine("CLOSE", 0, 1);
    sendLine("RELAY ON", 0, 1);
    `CHK("relayOut", 3'h0, relayOut)
    sendLine("OPEN", 0, 1);
    sendLine("OPEN XY", 0, 1);
    `CHK("cmdMode", 1'b0, cmdMode)
    expLine(string'(TXT_OPENED));
    sendLine("OPEN AB", 0, 1);
    `CHK("cmdMode", 1'b1, cmdMode)
    expLine("RELAYS OFF OFF OFF");
    sendLine("RELAY", 0, 1);
    relayAlarm = 3'h4;
    sendLine("RELAY 2 ON", 0, 1);
    `CHK("relayOut", 3'h6, relayOut)
    expLine("RELAYS OFF ON ON");
    sendLine("RELAY", 0, 1);
    sendLine("\033", 0, 0);
    `CHK("relayOut", 3'h4, relayOut)
    relayAlarm = 3'h0;
    sendLine("RELAY ON", 0, 1);
    `CHK("relayOut", 3'h7, relayOut)
    sendLine("\033", 0, 0);
    expLine("STATUS");
    sendLine(string'(WORD_RPT), 0, 1);
    alarmFlags = 8'h05;
    expLine("STATUS A0 A2");
    sendLine(string'(WORD_RPT), 0, 1);
    expLine(string'(TXT_CLOSED));
    sendLine("CLOSE", 0, 1);
    `CHK("cmdMode", 1'b0, cmdMode)
    $display("test command mode done");
    opens = '{"OPEN *", "OPEN \003", {"OPEN ", string'(SENSOR_TYPE_TAG), " 5"}};
    foreach (opens[i]) begin
      expLine(string'(TXT_OPENED));
      sendLine(opens[i], 0, 1);
      `CHK("cmdMode", 1'b1, cmdMode)
      if (i < 2) begin
        expLine(string'(TXT_CLOSED));
        sendLine("CLOSE", 0, 1);
      end
    end
    repeat (INACT) @(negedge clk);
    `CHK("cmdMode", 1'b0, cmdMode)
    expHead(unitId);
    expStr("13 20000  0  0.00");
    expTail;
    sendLine({"\005", string'(SENSOR_TYPE_TAG), " AB 1"}, 0, 1);
    $display("test open forms and poll done");
    sendLine("X", 1, 0);
    `CHK("mpBlocked", 1'b1, mpBlocked)
    sendLine("OPEN AB", 0, 1);
    `CHK("cmdMode", 1'b0, cmdMode)
    repeat (SVC) @(negedge clk);
    `CHK("mpBlocked", 1'b0, mpBlocked)
    $display("test service block done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
